// file: itlc_counter.sv
`timescale 1ns/1ps
`include "itlc_params.svh"
module itlc_counter #(
    parameter itlc_pkg::itlc_mode_e MODE = itlc_pkg::ITLC_RATE
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_init,
    input  wire logic                  i_first,
    input  wire logic                  i_load,
    input  wire logic                  i_tick,
    input  wire itlc_pkg::itlc_count_t i_preload,
    output logic [15:0]                o_count,
    output logic                       o_out
);
    import itlc_pkg::*;

    localparam logic OUT_INIT = (MODE == ITLC_TERM) ? 1'b0 : 1'b1;

    itlc_state_e state_ff;
    itlc_count_t ce_ff;
    logic        out_ff;

    // Square-wave half lengths; a count of one gets the long special case so no half is empty.
    function automatic itlc_count_t half_len(input itlc_count_t n, input logic high);
        logic [16:0] full;
        full = (n == `ITLC_COUNT_RST) ? `ITLC_FULL_COUNT : {1'b0, n};
        if (n == `ITLC_COUNT_ONE)
            half_len = high ? `ITLC_SQ1_HIGH : `ITLC_SQ1_LOW;
        else if (high)
            half_len = 16'((full + `ITLC_ONE17) >> 1);
        else
            half_len = 16'(full >> 1);
    endfunction : half_len

    always_ff @(posedge i_clk) begin
        if (i_rst || i_init) begin
            state_ff <= ITLC_WAIT;
            out_ff   <= OUT_INIT;
            if (i_rst)
                ce_ff <= `ITLC_COUNT_RST;
        end else if (i_first && MODE == ITLC_TERM) begin
            state_ff <= ITLC_WAIT;
            out_ff   <= 1'b0;
        end else if (i_load && (state_ff != ITLC_RUN || MODE == ITLC_TERM)) begin
            state_ff <= ITLC_ARM;
        end else if (i_tick) begin
            case (state_ff)
                ITLC_ARM: begin
                    state_ff <= ITLC_RUN;
                    if (MODE == ITLC_SQUARE) begin
                        ce_ff  <= half_len(i_preload, 1'b1);
                        out_ff <= 1'b1;
                    end else begin
                        ce_ff <= i_preload;
                        if (MODE == ITLC_RATE)
                            out_ff <= (i_preload != `ITLC_COUNT_ONE);
                    end
                end
                ITLC_RUN: begin
                    if (MODE == ITLC_RATE) begin
                        if (ce_ff == `ITLC_COUNT_ONE) begin
                            ce_ff  <= i_preload;
                            out_ff <= (i_preload != `ITLC_COUNT_ONE);
                        end else begin
                            ce_ff  <= ce_ff - `ITLC_COUNT_ONE;
                            out_ff <= (ce_ff != `ITLC_COUNT_TWO);
                        end
                    end else if (MODE == ITLC_TERM) begin
                        ce_ff <= ce_ff - `ITLC_COUNT_ONE;
                        if (ce_ff == `ITLC_COUNT_ONE)
                            out_ff <= 1'b1;
                    end else begin
                        if (ce_ff == `ITLC_COUNT_ONE) begin
                            out_ff <= ~out_ff;
                            ce_ff  <= half_len(i_preload, ~out_ff);
                        end else begin
                            ce_ff <= ce_ff - `ITLC_COUNT_ONE;
                        end
                    end
                end
                default: state_ff <= state_ff;
            endcase
        end
    end

    assign o_count = ce_ff;
    assign o_out   = out_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_init_out;
        i_init |=> (o_out == OUT_INIT) && (state_ff == ITLC_WAIT);
    endproperty
    a_init_out: assert property (p_init_out) else $error("Output not at initial level after init.");

    property p_rate_low;
        (MODE == ITLC_RATE && state_ff == ITLC_RUN) |-> (o_out == (ce_ff != `ITLC_COUNT_ONE));
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("Rate output not low exactly at count one.");

    property p_term_high;
        (MODE == ITLC_TERM && state_ff == ITLC_RUN && i_tick && ce_ff == `ITLC_COUNT_ONE
         && !i_init && !i_first && !i_load) |=> o_out && (ce_ff == `ITLC_COUNT_RST);
    endproperty
    a_term_high: assert property (p_term_high) else $error("Delay output not high at zero.");

    property p_square_flip;
        (MODE == ITLC_SQUARE && state_ff == ITLC_RUN && i_tick && ce_ff == `ITLC_COUNT_ONE && !i_init)
            |=> (o_out != $past(o_out));
    endproperty
    a_square_flip: assert property (p_square_flip) else $error("Square output did not toggle.");

    c_square_flip: cover property (MODE == ITLC_SQUARE && $fell(o_out));
    c_term_expire: cover property (MODE == ITLC_TERM && $rose(o_out));
endmodule : itlc_counter

// file: itlc_host_model.sv
`timescale 1ns/1ps
module itlc_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic [7:0]      o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_wdata
);
    int gap = 0;

    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end

    // One strobe cycle per byte; address and data are inverted afterwards so a stale value never looks valid.
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = w;
        o_rd = !w;
        @(posedge i_clk);
        #1;
        q = i_rdata;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
        repeat (gap) begin
            @(posedge i_clk);
            #1;
        end
    endtask : access
endmodule : itlc_host_model

// file: itlc_params.svh
// Behaviour
// - Counter 0 rate generator, low one clock
// - Counter 1 clocked by tick, high at zero
// - Counter 2 square wave, high half rounded up
// - Modes fixed, only predefined control bytes accepted
// - Counter 1 init byte: 01 11 000 0
// - Counter 2 init byte: 10110110
// - Latch freezes count, counting continues undisturbed
// - Latch bytes 00h, 40h, 80h select counter
// - Low byte read auto-latches when not latched
// - High byte read releases the holding latch
// - Latch command ignored while latch unread
`ifndef ITLC_PARAMS_SVH
`define ITLC_PARAMS_SVH

`define ITLC_NUM_CH       3
`define ITLC_ADDR_CNT0    8'hE8
`define ITLC_ADDR_CNT1    8'hEA
`define ITLC_ADDR_CNT2    8'hEC
`define ITLC_ADDR_CTRL    8'hEE
`define ITLC_INIT_CNT0    8'h34
`define ITLC_INIT_CNT1    8'h70
`define ITLC_INIT_CNT2    8'hB6
`define ITLC_LATCH_CNT0   8'h00
`define ITLC_LATCH_CNT1   8'h40
`define ITLC_LATCH_CNT2   8'h80
`define ITLC_RDATA_IDLE   8'h00
`define ITLC_BYTE_RST     8'h00
`define ITLC_COUNT_RST    16'h0000
`define ITLC_COUNT_ONE    16'h0001
`define ITLC_COUNT_TWO    16'h0002
`define ITLC_FULL_COUNT   17'h10000
`define ITLC_ONE17        17'h00001
`define ITLC_SQ1_HIGH     16'h8001
`define ITLC_SQ1_LOW      16'h8000

`endif

// file: itlc_pkg.sv
package itlc_pkg;
    typedef enum logic [1:0] {
        ITLC_RATE,
        ITLC_TERM,
        ITLC_SQUARE
    } itlc_mode_e;

    typedef enum logic [1:0] {
        ITLC_WAIT,
        ITLC_ARM,
        ITLC_RUN
    } itlc_state_e;

    typedef logic [15:0] itlc_count_t;
endpackage : itlc_pkg

// file: itlc_tb_top.sv
`timescale 1ns/1ps
module itlc_tb_top;
    logic        i_clk;
    logic        i_rst;
    logic        wr;
    logic        rd;
    logic        tclk0;
    logic        tclk2;
    logic        run0;
    logic        run2;
    logic        ph;
    logic        tick;
    logic        delay;
    logic        baud;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [31:0] seed;
    logic [15:0] va;
    logic [15:0] va2;
    logic [15:0] vb;
    logic [15:0] vc;
    logic [7:0]  addr_c [3] = '{8'hE8, 8'hEA, 8'hEC};
    logic [7:0]  init_c [3] = '{8'h34, 8'h70, 8'hB6};
    logic [7:0]  latch_c [3] = '{8'h00, 8'h40, 8'h80};
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          falls0 = 0;
    int          falls1 = 0;
    int          falls2 = 0;
    int          ft0 = 0;
    logic        tick_q = 1'b1;
    localparam int BAUD_N = 39;
    int          n0;
    int          n1;
    int          n;
    int          k;
    int          fa;

    itlc_top i_itlc_top (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd),
        .i_io_wdata(wdata), .o_io_rdata(rdata), .i_tclk0(tclk0), .i_tclk2(tclk2),
        .o_system_tick_output(tick), .o_delay_out(delay), .o_baud_out(baud));
    itlc_host_model i_itlc_host_model (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Run flags are sampled at the edge so the main sequence never races the counter clocks.
    always @(posedge i_clk) begin
        automatic logic g0 = run0 && ph;
        automatic logic g2 = run2 && ph;
        #1;
        ph = ~ph;
        if (g0) begin
            falls0 = falls0 + int'(tclk0);
            tclk0 = ~tclk0;
        end
        if (g2) begin
            falls2 = falls2 + int'(tclk2);
            tclk2 = ~tclk2;
        end
    end

    // Falls of the tick output are the input clocks of counter 1.
    always @(posedge i_clk) begin
        #1;
        if (tick_q === 1'b1 && tick === 1'b0) begin
            falls1++;
        end
        tick_q = tick;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            results();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic sig(input int s);
        return (s == 0) ? tick : ((s == 1) ? delay : baud);
    endfunction : sig

    // Rate mode count after f input falls: the first fall loads n0, then n0 down to 1 and reload.
    function automatic logic [15:0] cnt0(input int f);
        return 16'(((n0 - f % n0) % n0) + 1);
    endfunction : cnt0

    function automatic int falls(input int ch);
        return (ch == 0) ? falls0 : ((ch == 1) ? falls1 : falls2);
    endfunction : falls

    // Counter 1 loads n1 on its first tick after load; counter 2 counts the high half, then the low half.
    function automatic logic [15:0] model(input int ch, input int f);
        int p;
        p = (f - 1) % BAUD_N;
        if (ch == 0)
            return cnt0(f);
        else if (ch == 1)
            return 16'(n1 + 1 - (f - ft0));
        else
            return 16'((p < (BAUD_N + 1) / 2) ? ((BAUD_N + 1) / 2 - p) : (BAUD_N - p));
    endfunction : model

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_itlc_host_model.access(a, 1'b1, d, q);
    endtask : wr_b

    task automatic rd_b(input logic [7:0] a, output logic [7:0] q);
        i_itlc_host_model.access(a, 1'b0, 8'h00, q);
    endtask : rd_b

    task automatic run_clk(input int c);
        run0 = 1'b1;
        run2 = 1'b1;
        repeat (c) @(posedge i_clk);
        #1;
        run0 = 1'b0;
        run2 = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : run_clk

    task automatic prog(input int ch, input logic [15:0] v);
        wr_b(8'hEE, init_c[ch]);
        wr_b(addr_c[ch], v[7:0]);
        wr_b(addr_c[ch], v[15:8]);
    endtask : prog

    task automatic rdv(input int ch, input int c, output logic [15:0] v);
        rd_b(addr_c[ch], v[7:0]);
        if (c > 0) begin
            run_clk(c);
        end
        rd_b(addr_c[ch], v[15:8]);
    endtask : rdv

    task automatic wait_lvl(input int s, input logic v, output int w);
        w = 0;
        while (sig(s) !== v && w < 9000) begin
            @(posedge i_clk);
            #1;
            w++;
        end
    endtask : wait_lvl

    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        i_rst = 1'b1;
        tclk0 = 1'b1;
        tclk2 = 1'b1;
        run0 = 1'b0;
        run2 = 1'b0;
        ph = 1'b0;
        seed = lfsr(32'h2E03);
        n0 = 260 + int'(seed[6:0]);
        n1 = 1 + int'(seed[9:8]);
        repeat (12) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk("idle outputs", 16'h0005, {13'h0000, tick, delay, baud});
        rd_b(8'hEE, va[7:0]);
        chk("control port read", 16'h0000, {8'h00, va[7:0]});
        prog(0, 16'(n0));
        run0 = 1'b1;
        wait_lvl(0, 1'b0, n);
        wait_lvl(0, 1'b1, n);
        chk("tick low width", 16'd4, 16'(n));
        wait_lvl(0, 1'b0, n);
        chk("tick high width", 16'((n0 - 1) * 4), 16'(n));
        prog(2, 16'(BAUD_N));
        run2 = 1'b1;
        wait_lvl(2, 1'b0, n);
        wait_lvl(2, 1'b1, n);
        chk("baud low width", 16'((BAUD_N / 2) * 4), 16'(n));
        wait_lvl(2, 1'b0, n);
        chk("baud high width", 16'(((BAUD_N + 1) / 2) * 4), 16'(n));
        wait_lvl(0, 1'b0, n);
        prog(1, 16'(n1));
        ft0 = falls1;
        chk("delay armed", 16'h0000, {15'h0000, delay});
        k = 0;
        while (delay !== 1'b1 && k < 8) begin
            wait_lvl(0, 1'b1, n);
            wait_lvl(0, 1'b0, n);
            k++;
            repeat (4) @(posedge i_clk);
            #1;
        end
        chk("delay tick count", 16'(n1 + 1), 16'(k));
        run0 = 1'b0;
        run2 = 1'b0;
        repeat (4) @(posedge i_clk);
        for (int ch = 0; ch < 3; ch++) begin
            seed = lfsr(seed);
            i_itlc_host_model.gap = int'(seed[0]);
            fa = falls(ch);
            rdv(ch, 400, va);
            rdv(ch, 0, va2);
            chk("auto latch", model(ch, fa), va);
            chk("released count", model(ch, falls(ch)), va2);
            wr_b(8'hEE, latch_c[ch]);
            run_clk(800);
            wr_b(8'hEE, {4'h1, seed[4:1]});
            wr_b(8'hEE, latch_c[ch]);
            run_clk(800);
            rdv(ch, 0, vb);
            chk("latched count", va2, vb);
            rdv(ch, 0, vc);
            chk("live count", model(ch, falls(ch)), vc);
        end
        results();
    end
endmodule : itlc_tb_top

// file: itlc_top.sv
`timescale 1ns/1ps
`include "itlc_params.svh"
module itlc_top (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_io_addr,
    input  wire logic       i_io_wr,
    input  wire logic       i_io_rd,
    input  wire logic [7:0] i_io_wdata,
    output logic [7:0]      o_io_rdata,
    input  wire logic       i_tclk0,
    input  wire logic       i_tclk2,
    output logic            o_system_tick_output,
    output logic            o_delay_out,
    output logic            o_baud_out
);
    import itlc_pkg::*;

    // Declared ahead of the generate loop so the per-channel assertions pick up clock and reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    localparam int NCH = `ITLC_NUM_CH;
    localparam logic [7:0] CH_ADDR    [NCH] = '{`ITLC_ADDR_CNT0, `ITLC_ADDR_CNT1, `ITLC_ADDR_CNT2};
    localparam logic [7:0] INIT_BYTE  [NCH] = '{`ITLC_INIT_CNT0, `ITLC_INIT_CNT1, `ITLC_INIT_CNT2};
    localparam logic [7:0] LATCH_BYTE [NCH] = '{`ITLC_LATCH_CNT0, `ITLC_LATCH_CNT1, `ITLC_LATCH_CNT2};
    localparam itlc_mode_e CH_MODE    [NCH] = '{ITLC_RATE, ITLC_TERM, ITLC_SQUARE};

    logic              ctl_wr;
    logic              ctl_known;
    logic [NCH-1:0]    sel_w;
    logic [NCH-1:0]    sel_r;
    logic [NCH-1:0]    init_w;
    logic [NCH-1:0]    latch_w;
    logic [NCH-1:0]    tick;
    logic [NCH-1:0]    cnt_out;
    logic [NCH-1:0]    wr_hi_ff;
    logic [NCH-1:0]    rd_hi_ff;
    logic [NCH-1:0]    latched_ff;
    logic [7:0]        lsb_ff   [NCH];
    itlc_count_t       cr_ff    [NCH];
    itlc_count_t       ol_ff    [NCH];
    itlc_count_t       count    [NCH];
    logic [7:0]        rbyte    [NCH];
    logic [7:0]        nxt_rdata;
    logic              tclk0_ff;
    logic              tclk2_ff;
    logic              tick_out_ff;
    logic [7:0]        rdata_ff;

    assign ctl_wr    = i_io_wr && (i_io_addr == `ITLC_ADDR_CTRL);
    assign ctl_known = |init_w || |latch_w;

    // Counter inputs count on falling edges; counter 1 counts falls of counter 0's tick.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tclk0_ff    <= 1'b0;
            tclk2_ff    <= 1'b0;
            tick_out_ff <= 1'b1;
        end else begin
            tclk0_ff    <= i_tclk0;
            tclk2_ff    <= i_tclk2;
            tick_out_ff <= cnt_out[0];
        end
    end

    assign tick[0] = tclk0_ff && !i_tclk0;
    assign tick[1] = tick_out_ff && !cnt_out[0];
    assign tick[2] = tclk2_ff && !i_tclk2;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign sel_w[g]   = i_io_wr && (i_io_addr == CH_ADDR[g]);
            assign sel_r[g]   = i_io_rd && (i_io_addr == CH_ADDR[g]);
            // Only the fixed bytes act; anything else on the control port falls through.
            assign init_w[g]  = ctl_wr && (i_io_wdata == INIT_BYTE[g]);
            assign latch_w[g] = ctl_wr && (i_io_wdata == LATCH_BYTE[g]);

            // The preload changes only when both bytes are in, so a half-written value is never used.
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    wr_hi_ff[g] <= 1'b0;
                    lsb_ff[g]   <= `ITLC_BYTE_RST;
                    cr_ff[g]    <= `ITLC_COUNT_RST;
                end else if (init_w[g]) begin
                    wr_hi_ff[g] <= 1'b0;
                end else if (sel_w[g]) begin
                    wr_hi_ff[g] <= ~wr_hi_ff[g];
                    if (wr_hi_ff[g])
                        cr_ff[g] <= {i_io_wdata, lsb_ff[g]};
                    else
                        lsb_ff[g] <= i_io_wdata;
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    rd_hi_ff[g]   <= 1'b0;
                    latched_ff[g] <= 1'b0;
                    ol_ff[g]      <= `ITLC_COUNT_RST;
                end else if (init_w[g]) begin
                    rd_hi_ff[g]   <= 1'b0;
                    latched_ff[g] <= 1'b0;
                end else if (sel_r[g]) begin
                    rd_hi_ff[g] <= ~rd_hi_ff[g];
                    if (rd_hi_ff[g]) begin
                        latched_ff[g] <= 1'b0;
                    end else if (!latched_ff[g]) begin
                        latched_ff[g] <= 1'b1;
                        ol_ff[g]      <= count[g];
                    end
                end else if (latch_w[g] && !latched_ff[g]) begin
                    latched_ff[g] <= 1'b1;
                    ol_ff[g]      <= count[g];
                end
            end

            assign rbyte[g] = rd_hi_ff[g] ? ol_ff[g][15:8]
                                          : (latched_ff[g] ? ol_ff[g][7:0] : count[g][7:0]);

            itlc_counter #(
                .MODE (CH_MODE[g])
            ) u_cnt (
                .i_clk     (i_clk),
                .i_rst     (i_rst),
                .i_init    (init_w[g]),
                .i_first   (sel_w[g] && !wr_hi_ff[g]),
                .i_load    (sel_w[g] && wr_hi_ff[g]),
                .i_tick    (tick[g]),
                .i_preload (cr_ff[g]),
                .o_count   (count[g]),
                .o_out     (cnt_out[g])
            );

            property p_latch_take;
                (latch_w[g] && !latched_ff[g]) |=> latched_ff[g] && (ol_ff[g] == $past(count[g]));
            endproperty
            a_latch_take: assert property (p_latch_take) else $error("Latch command did not capture count.");

            property p_latch_ignore;
                (latch_w[g] && latched_ff[g]) |=> latched_ff[g] && $stable(ol_ff[g]);
            endproperty
            a_latch_ignore: assert property (p_latch_ignore) else $error("Second latch command was not ignored.");

            property p_auto_latch;
                (sel_r[g] && !rd_hi_ff[g] && !latched_ff[g])
                    |=> latched_ff[g] && (ol_ff[g] == $past(count[g])) && (o_io_rdata == $past(count[g][7:0]));
            endproperty
            a_auto_latch: assert property (p_auto_latch) else $error("Low byte read did not latch count.");

            property p_release;
                (sel_r[g] && rd_hi_ff[g]) |=> !latched_ff[g] && (o_io_rdata == $past(ol_ff[g][15:8]));
            endproperty
            a_release: assert property (p_release) else $error("High byte read did not release latch.");

            property p_bad_ctl;
                (ctl_wr && !ctl_known) |=> $stable(cr_ff[g]) && $stable(ol_ff[g]) && $stable(latched_ff[g]);
            endproperty
            a_bad_ctl: assert property (p_bad_ctl) else $error("Unknown control byte changed state.");

            property p_low_hold;
                (sel_w[g] && !wr_hi_ff[g]) |=> $stable(cr_ff[g]) && wr_hi_ff[g];
            endproperty
            a_low_hold: assert property (p_low_hold) else $error("Low byte write changed the preload.");

            property p_preload_pair;
                (sel_w[g] && wr_hi_ff[g]) |=> !wr_hi_ff[g] && (cr_ff[g] == {$past(i_io_wdata), $past(lsb_ff[g])});
            endproperty
            a_preload_pair: assert property (p_preload_pair) else $error("High byte write did not set preload.");

            property p_latched_low;
                (sel_r[g] && !rd_hi_ff[g] && latched_ff[g])
                    |=> latched_ff[g] && (o_io_rdata == $past(ol_ff[g][7:0]));
            endproperty
            a_latched_low: assert property (p_latched_low) else $error("Latched low byte not returned.");
        end
    endgenerate

    always_comb begin
        nxt_rdata = `ITLC_RDATA_IDLE;
        for (int i = 0; i < NCH; i++) begin
            if (sel_r[i])
                nxt_rdata = rbyte[i];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            rdata_ff <= `ITLC_RDATA_IDLE;
        else if (i_io_rd)
            rdata_ff <= nxt_rdata;
    end

    assign o_io_rdata           = rdata_ff;
    assign o_system_tick_output = cnt_out[0];
    assign o_delay_out          = cnt_out[1];
    assign o_baud_out           = cnt_out[2];

    // The control port is write-only, so a read of it must never leak counter state.
    property p_ctl_read_idle;
        (i_io_rd && (i_io_addr == `ITLC_ADDR_CTRL)) |=> (o_io_rdata == `ITLC_RDATA_IDLE);
    endproperty
    a_ctl_read_idle: assert property (p_ctl_read_idle) else $error("Control port read was not idle.");

    property p_init_tick;
        init_w[0] |=> o_system_tick_output;
    endproperty
    a_init_tick: assert property (p_init_tick) else $error("Counter 0 init did not raise tick.");

    property p_init_baud;
        init_w[2] |=> o_baud_out;
    endproperty
    a_init_baud: assert property (p_init_baud) else $error("Counter 2 init did not raise baud.");

    property p_init_ptr;
        init_w[1] |=> !wr_hi_ff[1] && !rd_hi_ff[1] && !latched_ff[1] && !o_delay_out;
    endproperty
    a_init_ptr: assert property (p_init_ptr) else $error("Counter 1 init did not reset access state.");

    // The tick strobe stands in the very cycle in which the falling level is first seen.
    property p_tick_chain;
        $fell(o_system_tick_output) |-> tick[1];
    endproperty
    a_tick_chain: assert property (p_tick_chain) else $error("Counter 1 missed a tick edge.");

    c_latch_read: cover property ((sel_r[0] && !rd_hi_ff[0]) ##[1:20] (sel_r[0] && rd_hi_ff[0]));
    c_rate_tick: cover property ($fell(o_system_tick_output) ##[1:40] $rose(o_system_tick_output));
    c_bad_ctl: cover property (ctl_wr && !ctl_known);
endmodule : itlc_top
